//--- orientation_config_irq.v
`timescale 1ns/1ps
`include "orientation_map.vh"
module orientation_config_irq #(
  parameter AW = 32,
  parameter MW = 8
) (
  input  wire          hclk,
  input  wire          hresetn,
  input  wire          hsel,
  input  wire [AW-1:0] haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hready,
  output reg  [31:0]   hrdata,
  output reg           hreadyout,
  output reg           hresp,
  input  wire          sample_valid,
  input  wire [1:0]    cand_2d,
  input  wire [MW-1:0] margin_2d,
  input  wire [2:0]    cand_3d,
  input  wire [MW-1:0] margin_3d,
  input  wire          overrun_event,
  output reg           irq,
  output reg           irq_pin_one,
  output reg           irq_pin_two
);

  reg  [7:0]  orientation_config_r;
  reg  [7:0]  rate_control_r;
  reg  [7:0]  power_control_r;
  reg  [7:0]  int_enable_r;
  reg  [7:0]  int_map_r;
  reg         orient_flag_r;
  reg         ovr_flag_r;

  // AHB data-phase state
  reg         wr_pend_r;
  reg         rd_pend_r;
  reg  [7:0]  idx_r;
  reg         hit_r;

  wire        addr_take = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];
  wire        addr_hit  = (haddr[AW-1:10] == {(AW-10){1'b0}}) && (haddr[1:0] == 2'b00);
  wire [7:0]  wd        = hwdata[7:0];

  wire        wr_rate   = wr_pend_r && hit_r && (idx_r == `IDX_RATE_CONTROL);
  wire        wr_power  = wr_pend_r && hit_r && (idx_r == `IDX_POWER_CONTROL);
  wire        wr_enable = wr_pend_r && hit_r && (idx_r == `IDX_INT_ENABLE);
  wire        wr_map    = wr_pend_r && hit_r && (idx_r == `IDX_INT_MAP);
  wire        wr_config = wr_pend_r && hit_r && (idx_r == `IDX_ORIENT_CONFIG);
  wire        wr_clear  = wr_pend_r && hit_r && (idx_r == `IDX_INT_CLEAR);
  wire        rd_source = rd_pend_r && hit_r && (idx_r == `IDX_INT_SOURCE);

  wire        orient_en = orientation_config_r[`OC_IRQ_EN_BIT];
  wire        sel_3d    = orientation_config_r[`OC_3D_SEL_BIT];
  wire [2:0]  dead_code = orientation_config_r[`OC_DEAD_MSB:`OC_DEAD_LSB];
  wire [2:0]  div_code  = orientation_config_r[`OC_DIV_MSB:`OC_DIV_LSB];
  wire        measuring = power_control_r[`PC_MEASURE_BIT];

  // table lookup in tenths of a degree, monotonic in the code
  wire [63:0] dead_tab_2d = `DEAD_TABLE_2D;
  wire [63:0] dead_tab_3d = `DEAD_TABLE_3D;
  wire [7:0]  dead_2d     = dead_tab_2d[{dead_code, 3'b000} +: 8];
  wire [7:0]  dead_3d     = dead_tab_3d[{dead_code, 3'b000} +: 8];
  wire [MW-1:0] dead_2d_w = {{(MW-8){1'b0}}, dead_2d};
  wire [MW-1:0] dead_3d_w = {{(MW-8){1'b0}}, dead_3d};

  // any value change on the rate register, or standby, restarts the detector
  wire        restart   = (wr_rate && (wd != rate_control_r)) || !measuring;
  wire        sample    = sample_valid && measuring;

  wire [1:0]  orient_2d;
  wire        valid_2d;
  wire        change_2d;
  wire [2:0]  orient_3d;
  wire        valid_3d;
  wire        change_3d;

  orientation_tracker #(.CW(2), .MW(MW)) track_2d (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .restart  (restart),
    .sample   (sample),
    .cand     (cand_2d),
    .margin   (margin_2d),
    .dead     (dead_2d_w),
    .div_code (div_code),
    .orient_r (orient_2d),
    .valid_r  (valid_2d),
    .change_r (change_2d)
  );

  orientation_tracker #(.CW(3), .MW(MW)) track_3d (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .restart  (restart),
    .sample   (sample),
    .cand     (cand_3d),
    .margin   (margin_3d),
    .dead     (dead_3d_w),
    .div_code (div_code),
    .orient_r (orient_3d),
    .valid_r  (valid_3d),
    .change_r (change_3d)
  );

  // interrupt only with enable set; select picks the 2-D or 3-D change
  wire        orient_evt = orient_en && (sel_3d ? change_3d : change_2d);
  // overrun only reaches the slot while orientation does not own it
  wire        ovr_evt    = overrun_event && !orient_en;

  wire        cfg_off    = wr_config && !wd[`OC_IRQ_EN_BIT];
  wire        orient_clr = rd_source || wr_rate || cfg_off || !measuring ||
                           (wr_clear && wd[`SLOT_BIT] && orient_en);
  wire        ovr_clr    = (wr_clear && wd[`SLOT_BIT] && !orient_en) ||
                           (rd_source && !orient_en);

  // slot shows orientation when enabled, else overrun
  wire        slot_flag  = orient_en ? orient_flag_r : ovr_flag_r;
  wire [7:0]  source_val = {7'h00, slot_flag};
  wire        slot_irq   = slot_flag && int_enable_r[`SLOT_BIT];

  reg  [7:0]  rd_mux;
  always @* begin
    case (idx_r)
      `IDX_RATE_CONTROL:  rd_mux = rate_control_r;
      `IDX_POWER_CONTROL: rd_mux = power_control_r;
      `IDX_INT_ENABLE:    rd_mux = int_enable_r;
      `IDX_INT_MAP:       rd_mux = int_map_r;
      `IDX_INT_SOURCE:    rd_mux = source_val;
      `IDX_ORIENT_CONFIG: rd_mux = orientation_config_r;
      `IDX_ORIENT_STATUS: rd_mux = {1'b0, valid_2d, orient_2d, valid_3d, orient_3d};
      default:            rd_mux = 8'h00;
    endcase
  end

  // bus slave: writes take their data phase with no wait; reads insert one
  // wait so a read right after a write sees the written value
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r     <= 8'h00;
      hit_r     <= 1'b0;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= `HRESP_OKAY;
    end else begin
      hresp <= `HRESP_OKAY;
      if (rd_pend_r) begin
        hrdata    <= {24'h000000, hit_r ? rd_mux : 8'h00};
        hreadyout <= 1'b1;
        rd_pend_r <= 1'b0;
      end else begin
        wr_pend_r <= addr_take && hwrite;
        if (addr_take) begin
          idx_r <= haddr[9:2];
          hit_r <= addr_hit;
          if (!hwrite) begin
            rd_pend_r <= 1'b1;
            hreadyout <= 1'b0;
          end
        end
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      orientation_config_r <= `ORIENT_CONFIG_RST;
      rate_control_r       <= `RATE_CONTROL_RST;
      power_control_r      <= `POWER_CONTROL_RST;
      int_enable_r         <= `INT_ENABLE_RST;
      int_map_r            <= `INT_MAP_RST;
    end else begin
      if (wr_config)
        orientation_config_r <= wd;
      if (wr_rate)
        rate_control_r <= wd;
      if (wr_power)
        power_control_r <= wd;
      if (wr_enable)
        int_enable_r <= wd;
      if (wr_map)
        int_map_r <= wd;
    end
  end

  // sticky flags: a new event in the clearing cycle wins
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      orient_flag_r <= 1'b0;
      ovr_flag_r    <= 1'b0;
    end else begin
      if (orient_evt)
        orient_flag_r <= 1'b1;
      else if (orient_clr)
        orient_flag_r <= 1'b0;
      if (ovr_evt)
        ovr_flag_r <= 1'b1;
      else if (ovr_clr)
        ovr_flag_r <= 1'b0;
    end
  end

  // map bit 0 sends the slot to pin one, 1 to pin two
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq         <= 1'b0;
      irq_pin_one <= 1'b0;
      irq_pin_two <= 1'b0;
    end else begin
      irq         <= slot_irq;
      irq_pin_one <= slot_irq && !int_map_r[`SLOT_BIT];
      irq_pin_two <= slot_irq && int_map_r[`SLOT_BIT];
    end
  end

endmodule // orientation_config_irq

//--- orientation_map.vh
`ifndef ORIENTATION_MAP_VH
`define ORIENTATION_MAP_VH

// register indices; byte address is four times the index
`define IDX_RATE_CONTROL    8'h2C
`define IDX_POWER_CONTROL   8'h2D
`define IDX_INT_ENABLE      8'h2E
`define IDX_INT_MAP         8'h2F
`define IDX_INT_SOURCE      8'h30
`define IDX_ORIENT_CONFIG   8'h3B
`define IDX_ORIENT_STATUS   8'h3C
`define IDX_INT_CLEAR       8'h3D

// orientation_config fields
`define OC_IRQ_EN_BIT       7
`define OC_DEAD_MSB         6
`define OC_DEAD_LSB         4
`define OC_3D_SEL_BIT       3
`define OC_DIV_MSB          2
`define OC_DIV_LSB          0

// power_control measure bit, 0 means standby
`define PC_MEASURE_BIT      3
// shared overrun / orientation slot in enable, map, source, clear
`define SLOT_BIT            0

// reset values
`define ORIENT_CONFIG_RST   8'h00
`define RATE_CONTROL_RST    8'h0A
`define POWER_CONTROL_RST   8'h00
`define INT_ENABLE_RST      8'h00
`define INT_MAP_RST         8'h00

// dead zone angles in tenths of a degree, code 0 in the low byte
`define DEAD_TABLE_2D       64'hAA9C8D7B67523A21
`define DEAD_TABLE_3D       64'hE6D1BAA082623F19

// AHB encodings
`define HTRANS_NONSEQ_BIT   1
`define HRESP_OKAY          1'b0

`endif

//--- orientation_tracker.v
`timescale 1ns/1ps
module orientation_tracker #(
  parameter CW = 2,
  parameter MW = 8
) (
  input  wire          hclk,
  input  wire          hresetn,
  input  wire          restart,
  input  wire          sample,
  input  wire [CW-1:0] cand,
  input  wire [MW-1:0] margin,
  input  wire [MW-1:0] dead,
  input  wire [2:0]    div_code,
  output reg  [CW-1:0] orient_r,
  output reg           valid_r,
  output reg           change_r
);
  localparam FW = 2 * MW;

  reg  [FW-1:0]   filt_r;
  reg             seen_r;
  wire [FW:0]     target  = {1'b0, margin, {MW{1'b0}}};
  wire [FW:0]     diff    = target - {1'b0, filt_r};
  wire [3:0]      shamt   = {1'b0, div_code} + 4'h1;
  // arithmetic shift of the signed difference: divisor is 2^(code+1)
  wire [FW:0]     step    = $signed(diff) >>> shamt;
  wire [FW-1:0]   filt_nxt = filt_r + step[FW-1:0];
  wire            in_band = (filt_nxt[FW-1:MW] > dead);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_r   <= {FW{1'b0}};
      orient_r <= {CW{1'b0}};
      valid_r  <= 1'b0;
      seen_r   <= 1'b0;
      change_r <= 1'b0;
    end else if (restart) begin
      // filter history, valid and seen flags are dropped on restart; orient_r keeps its value
      filt_r   <= {FW{1'b0}};
      valid_r  <= 1'b0;
      seen_r   <= 1'b0;
      change_r <= 1'b0;
    end else begin
      change_r <= 1'b0;
      if (sample) begin
        filt_r  <= filt_nxt;
        valid_r <= in_band;
        if (in_band) begin
          orient_r <= cand;
          seen_r   <= 1'b1;
          change_r <= seen_r && (cand != orient_r);
        end
      end
    end
  end
endmodule // orientation_tracker

//--- orientation_config_irq_chk.sv
`timescale 1ns/1ps
`include "orientation_map.vh"
module orientation_config_irq_chk #(
  parameter AW = 32
) (
  input wire          hclk,
  input wire          hresetn,
  input wire          hsel,
  input wire [AW-1:0] haddr,
  input wire [1:0]    htrans,
  input wire          hwrite,
  input wire [31:0]   hwdata,
  input wire          hready,
  input wire          sample_valid,
  input wire          overrun_event,
  input wire          irq,
  input wire          irq_pin_one,
  input wire          irq_pin_two
);
  reg  [7:0] idx_r;
  reg        wr_r;
  reg        en_r;
  reg        ie_r;
  reg        pc_r;
  reg  [2:0] idle_r;
  wire       take = hsel && hready && htrans[1];
  wire       wr_now = wr_r && hready;
  wire       stby_on = en_r && !pc_r;
  // mirror of the control bits the irq path depends on
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_r <= 8'h00;
      wr_r <= 1'b0;
      en_r <= 1'b0;
      ie_r <= 1'b0;
      pc_r <= 1'b0;
      idle_r <= 3'h0;
    end else begin
      if (hready) begin
        idx_r <= haddr[9:2];
        wr_r <= take && hwrite;
      end
      if (wr_now && idx_r == `IDX_ORIENT_CONFIG)
        en_r <= hwdata[`OC_IRQ_EN_BIT];
      if (wr_now && idx_r == `IDX_INT_ENABLE)
        ie_r <= hwdata[`SLOT_BIT];
      if (wr_now && idx_r == `IDX_POWER_CONTROL)
        pc_r <= hwdata[`PC_MEASURE_BIT];
      // a clear may land up to three edges after its address phase
      if (take)
        idle_r <= 3'h0;
      else if (idle_r != 3'h7)
        idle_r <= idle_r + 3'h1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_IRQ_EN: assert property (irq |-> $past(ie_r))
    else $error("irq without enable");
  AST_PIN_EXCL: assert property (!(irq_pin_one && irq_pin_two))
    else $error("both irq pins high");
  AST_SRC_CLR: assert property (take && !hwrite && haddr[9:2] == `IDX_INT_SOURCE |-> ##[1:5] !irq)
    else $error("source read did not clear irq");
  AST_RATE_CLR: assert property (take && hwrite && en_r && haddr[9:2] == `IDX_RATE_CONTROL |-> ##[1:5] !irq)
    else $error("rate write did not clear irq");
  AST_DIS_CLR: assert property (wr_now && en_r && idx_r == `IDX_ORIENT_CONFIG && !hwdata[7] |-> ##[1:4] !irq)
    else $error("disable did not clear irq");
  AST_STBY: assert property (stby_on && $past(stby_on, 3) |-> !irq)
    else $error("irq in standby");
  AST_OVR: assert property (overrun_event && !en_r && ie_r |-> ##[1:6] irq)
    else $error("overrun not reported");
  AST_STICKY: assert property (irq && idle_r >= 3'h4 |=> irq)
    else $error("irq dropped without clear");
  // sample edge, change pulse, flag, irq: the sample sits three edges back
  AST_CAUSE: assert property ($rose(irq) && en_r && $past(ie_r, 2) && $past(en_r, 3) |-> $past(sample_valid, 3))
    else $error("orientation irq without sample");
endmodule // orientation_config_irq_chk

bind orientation_config_irq orientation_config_irq_chk #(.AW(AW)) i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .sample_valid(sample_valid), .overrun_event(overrun_event),
  .irq(irq), .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two));

//--- sensor_model.sv
`timescale 1ns/1ps
module sensor_model (
  input wire       hclk,
  output reg       sample_valid,
  output reg [1:0] cand_2d,
  output reg [2:0] cand_3d,
  output reg [7:0] margin,
  output reg       overrun_event
);
  initial begin
    sample_valid = 1'b0;
    cand_2d = 2'h0;
    cand_3d = 3'h1;
    margin = 8'h00;
    overrun_event = 1'b0;
  end
  // codes go stale between samples, so they are scrambled there
  task turn(input [1:0] c2, input [2:0] c3);
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        sample_valid <= 1'b1;
        cand_2d <= c2;
        cand_3d <= c3;
        margin <= 8'hFF;
        @(posedge hclk);
        sample_valid <= 1'b0;
        cand_2d <= ~c2;
        cand_3d <= ~c3;
        margin <= 8'h00;
        @(posedge hclk);
      end
    end
  endtask
  // zero margin drags the filtered angle down into the dead zone
  task fade(input [1:0] c2, input [2:0] c3);
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1) begin
        sample_valid <= 1'b1;
        cand_2d <= c2;
        cand_3d <= c3;
        margin <= 8'h00;
        @(posedge hclk);
        sample_valid <= 1'b0;
        @(posedge hclk);
      end
    end
  endtask
  task ovr;
    begin
      overrun_event <= 1'b1;
      @(posedge hclk);
      overrun_event <= 1'b0;
      @(posedge hclk);
    end
  endtask
endmodule // sensor_model

//--- tb_top.sv
`timescale 1ns/1ps
`include "orientation_map.vh"
module tb_top;
  localparam CFG = `IDX_ORIENT_CONFIG;
  localparam SRC = `IDX_INT_SOURCE;
  localparam PWR = `IDX_POWER_CONTROL;
  reg         hclk;
  reg         hresetn;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  reg  [31:0] q;
  wire [31:0] hrdata;
  wire        hreadyout;
  wire        hresp;
  wire        sample_valid;
  wire [1:0]  cand_2d;
  wire [2:0]  cand_3d;
  wire [7:0]  margin;
  wire        overrun_event;
  wire        irq;
  wire        irq_pin_one;
  wire        irq_pin_two;
  integer     n_errors;
  integer     cmp_count;
  orientation_config_irq i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sample_valid(sample_valid), .cand_2d(cand_2d), .margin_2d(margin), .cand_3d(cand_3d),
    .margin_3d(margin), .overrun_event(overrun_event), .irq(irq), .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two));
  sensor_model i_sens (.hclk(hclk), .sample_valid(sample_valid), .cand_2d(cand_2d), .cand_3d(cand_3d),
    .margin(margin), .overrun_event(overrun_event));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task stop_test;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input string s, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        $display("unexpected %0s expected %h seen %h", s, e, g);
        n_errors = n_errors + 1;
      end
    end
  endtask
  task wait_ready;
    integer k;
    begin
      k = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1 && k < 20) begin
        k = k + 1;
        @(posedge hclk);
      end
      if (hreadyout !== 1'b1) begin
        n_errors = n_errors + 1;
        stop_test;
      end
    end
  endtask
  task bus(input [7:0] i, input w, input [7:0] d);
    begin
      hsel <= 1'b1;
      haddr <= {22'h0, i, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_ready;
      q = hrdata;
      chk("hresp", 32'h00000000, {31'h0, hresp});
    end
  endtask
  task rd(input [7:0] i, input [7:0] e, input string s);
    begin
      bus(i, 1'b0, 8'h00);
      chk(s, {24'h0, e}, q);
    end
  endtask
  // irq output lags its cause by a few edges
  task settle(input [2:0] e);
    begin
      repeat (6) @(posedge hclk);
      chk("irq pins", {29'h0, e}, {29'h0, irq, irq_pin_one, irq_pin_two});
    end
  endtask
  initial begin
    n_errors = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(CFG, `ORIENT_CONFIG_RST, "config reset");
    rd(`IDX_RATE_CONTROL, `RATE_CONTROL_RST, "rate reset");
    bus(CFG, 1'b1, 8'h5A);
    rd(CFG, 8'h5A, "config");
    rd(8'h01, 8'h00, "unmapped");
    $display("test registers done");
    bus(PWR, 1'b1, 8'h08);
    bus(`IDX_INT_ENABLE, 1'b1, 8'h01);
    bus(`IDX_INT_MAP, 1'b1, 8'h00);
    bus(CFG, 1'b1, 8'h90);
    i_sens.turn(2'h0, 3'h1);
    i_sens.turn(2'h1, 3'h1);
    settle(3'h6);
    i_sens.turn(2'h2, 3'h1);
    settle(3'h6);
    rd(SRC, 8'h01, "source");
    settle(3'h0);
    i_sens.turn(2'h3, 3'h1);
    settle(3'h6);
    bus(`IDX_RATE_CONTROL, 1'b1, 8'h0A);
    settle(3'h0);
    i_sens.turn(2'h0, 3'h1);
    settle(3'h6);
    bus(PWR, 1'b1, 8'h00);
    settle(3'h0);
    bus(PWR, 1'b1, 8'h08);
    i_sens.turn(2'h1, 3'h1);
    bus(`IDX_RATE_CONTROL, 1'b1, 8'h0B);
    i_sens.turn(2'h2, 3'h1);
    settle(3'h0);
    i_sens.turn(2'h3, 3'h1);
    settle(3'h6);
    bus(CFG, 1'b1, 8'h10);
    settle(3'h0);
    bus(CFG, 1'b1, 8'h98);
    i_sens.turn(2'h2, 3'h1);
    i_sens.turn(2'h3, 3'h1);
    settle(3'h0);
    i_sens.turn(2'h3, 3'h4);
    settle(3'h6);
    rd(SRC, 8'h01, "source 3d");
    i_sens.fade(2'h3, 3'h4);
    i_sens.fade(2'h1, 3'h6);
    rd(`IDX_ORIENT_STATUS, 8'h34, "dead zone hold");
    settle(3'h0);
    $display("test orientation done");
    bus(CFG, 1'b1, 8'h10);
    bus(`IDX_INT_MAP, 1'b1, 8'h01);
    i_sens.ovr;
    settle(3'h5);
    rd(SRC, 8'h01, "overrun");
    settle(3'h0);
    i_sens.ovr;
    settle(3'h5);
    bus(`IDX_INT_CLEAR, 1'b1, 8'h01);
    settle(3'h0);
    bus(CFG, 1'b1, 8'h90);
    i_sens.ovr;
    settle(3'h0);
    rd(SRC, 8'h00, "slot");
    $display("test overrun done");
    stop_test;
  end
endmodule // tb_top
